// ==== hw/pfs_select_bank.sv ====
// apb register bank selecting the role of pins 30 to 49
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_select_bank
	import pfs_pkg::*;
#(
	parameter int NUM_PINS = 2 * `PFS_PINS_PER_REG
)
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [`PFS_ADDR_W-1:0]        paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [`PFS_PSTRB_W-1:0]       pstrb,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [NUM_PINS-1:0]           swOut,
	input  wire logic [NUM_PINS*`PFS_NUM_ALT-1:0] altOut,
	input  wire logic [NUM_PINS*`PFS_NUM_ALT-1:0] altOe,
	output logic [NUM_PINS-1:0]                padOut,
	output logic [NUM_PINS-1:0]                padOe,
	output pfs_pkg::pfs_role_t                 pinRole [NUM_PINS]
);
	import pfs_pkg::*;

	// the field map is fixed at two full registers
	if (NUM_PINS != 2 * `PFS_PINS_PER_REG)
	begin : g_bad_pins
		$error("pfs_select_bank: NUM_PINS must equal two registers");
	end

	logic [`PFS_USED_BITS-1:0] selLo_q;
	logic [`PFS_USED_BITS-1:0] selHi_q;
	logic                      access;
	logic                      hitLo;
	logic                      hitHi;

	// byte-lane merge limited to the implemented field bits
	function automatic logic [`PFS_USED_BITS-1:0] merge(
		input logic [`PFS_USED_BITS-1:0] old,
		input logic [31:0]               wd,
		input logic [`PFS_PSTRB_W-1:0]   strb
	);
		logic [31:0] m;
		m = 32'(old);
		for (int b = 0; b < `PFS_PSTRB_W; b++)
			if (strb[b])
				m[b*8 +: 8] = wd[b*8 +: 8];
		return m[`PFS_USED_BITS-1:0];
	endfunction

	// one-wait slave: pready rises in the cycle after the first access cycle
	assign access = psel & penable & ~pready;
	assign hitLo  = (paddr == `PFS_OFS_SEL_30_39);
	assign hitHi  = (paddr == `PFS_OFS_SEL_40_49);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			selLo_q <= `PFS_SEL_RESET;
		else if (access && pwrite && hitLo)
			selLo_q <= merge(selLo_q, pwdata, pstrb);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			selHi_q <= `PFS_SEL_RESET;
		else if (access && pwrite && hitHi)
			selHi_q <= merge(selHi_q, pwdata, pstrb);
	end

	// one-cycle ready pulse ends every access
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pready <= 1'b0;
		else
			pready <= access;
	end

	// unmapped address errors rather than silently aliasing
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pslverr <= 1'b0;
		else
			pslverr <= access & ~(hitLo | hitHi);
	end

	// top two bits read as zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata <= `PFS_REG_RESET;
		else if (access && !pwrite && hitLo)
			prdata <= {2'h0, selLo_q};
		else if (access && !pwrite && hitHi)
			prdata <= {2'h0, selHi_q};
		else
			prdata <= `PFS_REG_RESET;
	end

	logic [2*`PFS_USED_BITS-1:0] allSel;
	assign allSel = {selHi_q, selLo_q};

	// field i of the pair serves pin 30+i, lowest bits first
	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		pfs_pin_route u_route (
			.clk     (clk),
			.rst_n   (rst_n),
			.roleSel (allSel[i*`PFS_FIELD_W +: `PFS_FIELD_W]),
			.swOut   (swOut[i]),
			.altOut  (altOut[i*`PFS_NUM_ALT +: `PFS_NUM_ALT]),
			.altOe   (altOe[i*`PFS_NUM_ALT +: `PFS_NUM_ALT]),
			.padOut  (padOut[i]),
			.padOe   (padOe[i]),
			.role    (pinRole[i])
		);
	end

endmodule // pfs_select_bank

// ==== hw/pfs_defs.svh ====
// register offsets, field layout and role codes for the pin role select bank
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

`define PFS_OFS_SEL_30_39   12'h000
`define PFS_OFS_SEL_40_49   12'h004
`define PFS_ADDR_W          12
`define PFS_FIELD_W         3
`define PFS_PINS_PER_REG    10
`define PFS_PIN_BASE        30
`define PFS_USED_BITS       30
`define PFS_REG_RESET       32'h0000_0000
`define PFS_SEL_RESET       30'h0000_0000
`define PFS_FIELD_RESET     3'h0
`define PFS_CODE_INPUT      3'h0
`define PFS_CODE_OUTPUT     3'h1
`define PFS_CODE_ALT0       3'h4
`define PFS_CODE_ALT1       3'h5
`define PFS_CODE_ALT2       3'h6
`define PFS_CODE_ALT3       3'h7
`define PFS_CODE_ALT4       3'h3
`define PFS_CODE_ALT5       3'h2
`define PFS_NUM_ALT         6
`define PFS_PSTRB_W         4

`endif

// ==== hw/pfs_pkg.sv ====
// types shared by the pin role select bank
package pfs_pkg;

	// role a pin takes, decoded from its select field
	typedef enum logic [2:0] {
		PFS_ROLE_INPUT,
		PFS_ROLE_OUTPUT,
		PFS_ROLE_ALT0,
		PFS_ROLE_ALT1,
		PFS_ROLE_ALT2,
		PFS_ROLE_ALT3,
		PFS_ROLE_ALT4,
		PFS_ROLE_ALT5
	} pfs_role_t;

	typedef logic [2:0] pfs_field_t;

endpackage

// ==== hw/pfs_pin_route.sv ====
// one pin's output routing, driven by its registered select field
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_pin_route
	import pfs_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire pfs_pkg::pfs_field_t        roleSel,
	input  wire logic                       swOut,
	input  wire logic [`PFS_NUM_ALT-1:0]    altOut,
	input  wire logic [`PFS_NUM_ALT-1:0]    altOe,
	output logic                            padOut,
	output logic                            padOe,
	output pfs_pkg::pfs_role_t              role
);
	import pfs_pkg::*;

	pfs_role_t roleD;
	logic      outD;
	logic      oeD;

	always_comb
	begin
		roleD = PFS_ROLE_INPUT;
		outD  = 1'b0;
		oeD   = 1'b0;
		unique case (roleSel)
			`PFS_CODE_INPUT:
			begin
				roleD = PFS_ROLE_INPUT;
			end
			`PFS_CODE_OUTPUT:
			begin
				roleD = PFS_ROLE_OUTPUT;
				outD  = swOut;
				oeD   = 1'b1;
			end
			`PFS_CODE_ALT0:
			begin
				roleD = PFS_ROLE_ALT0;
				outD  = altOut[0];
				oeD   = altOe[0];
			end
			`PFS_CODE_ALT1:
			begin
				roleD = PFS_ROLE_ALT1;
				outD  = altOut[1];
				oeD   = altOe[1];
			end
			`PFS_CODE_ALT2:
			begin
				roleD = PFS_ROLE_ALT2;
				outD  = altOut[2];
				oeD   = altOe[2];
			end
			`PFS_CODE_ALT3:
			begin
				roleD = PFS_ROLE_ALT3;
				outD  = altOut[3];
				oeD   = altOe[3];
			end
			`PFS_CODE_ALT4:
			begin
				roleD = PFS_ROLE_ALT4;
				outD  = altOut[4];
				oeD   = altOe[4];
			end
			`PFS_CODE_ALT5:
			begin
				roleD = PFS_ROLE_ALT5;
				outD  = altOut[5];
				oeD   = altOe[5];
			end
		endcase
	end

	// registered so the pad never sees decode glitches
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			padOut <= 1'b0;
			padOe  <= 1'b0;
			role   <= PFS_ROLE_INPUT;
		end
		else
		begin
			padOut <= outD;
			padOe  <= oeD;
			role   <= roleD;
		end
	end

endmodule // pfs_pin_route

// ==== verif/pfs_select_bank_sva.sv ====
// port assertions for the pin role select bank
`timescale 1ns/1ps

module pfs_select_bank_chk
	import pfs_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic [19:0] padOe,
	input wire pfs_role_t   pinRole [20]
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wr;
	assign wr = psel && penable && pready && pwrite && pstrb == 4'hf;
	AST_READY: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	AST_RSV: assert property (pready && !pwrite |-> prdata[31:30] == 2'h0)
		else $error("reserved bits read nonzero");
	AST_MAP30: assert property (wr && paddr == 12'h000
		&& pwdata[2:0] == 3'h4 |=> pinRole[0] == PFS_ROLE_ALT0)
		else $error("pin 30 field misplaced");
	AST_MAP39: assert property (wr && paddr == 12'h000
		&& pwdata[29:27] == 3'h1 |=> pinRole[9] == PFS_ROLE_OUTPUT)
		else $error("pin 39 field misplaced");
	AST_MAP40: assert property (wr && paddr == 12'h004
		&& pwdata[2:0] == 3'h3 |=> pinRole[10] == PFS_ROLE_ALT4)
		else $error("pin 40 field misplaced");
	AST_MAP49: assert property (wr && paddr == 12'h004
		&& pwdata[29:27] == 3'h2 |=> pinRole[19] == PFS_ROLE_ALT5)
		else $error("pin 49 field misplaced");
	AST_IN: assert property (pinRole[5] == PFS_ROLE_INPUT |-> !padOe[5])
		else $error("input pin driven");
endmodule // pfs_select_bank_chk

bind pfs_select_bank pfs_select_bank_chk u_chk (.clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .padOe,
	.pinRole);

// ==== verif/pfs_pad_model.sv ====
// peripheral sources and software levels feeding the pins
`timescale 1ns/1ps

module pfs_pad_model
(
	input  wire logic clk,
	output logic [19:0]  swOut = '0,
	output logic [119:0] altOut = '0,
	output logic [119:0] altOe = '0
);
	// patterns change every cycle so a stale route shows
	always @(posedge clk)
	begin
		swOut <= swOut + 20'h1;
		altOut <= {altOut[118:0], ~altOut[119]};
		altOe <= ~altOe;
	end
endmodule // pfs_pad_model

// ==== verif/test_pin_function_select_bank.sv ====
// self-checking bench for the pin role select bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end

module test_pin_function_select_bank;
	import pfs_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, d, m [2];
	logic [3:0] pstrb = '0, s;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [19:0] swOut, padOut, padOe;
	logic [119:0] altOut, altOe;
	pfs_role_t pinRole [20];
	logic [19:0] swPrev;
	logic [119:0] aoPrev, aePrev;
	logic [1:0] pe;
	int n_fail = 0, samples_checked = 0, seed = 32'he884, idx;
	pfs_role_t roleTbl [8] = '{PFS_ROLE_INPUT, PFS_ROLE_OUTPUT,
		PFS_ROLE_ALT5, PFS_ROLE_ALT4, PFS_ROLE_ALT0, PFS_ROLE_ALT1,
		PFS_ROLE_ALT2, PFS_ROLE_ALT3};

	pfs_pad_model peer (.clk, .swOut, .altOut, .altOe);
	pfs_select_bank dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .swOut, .altOut,
		.altOe, .padOut, .padOe, .pinRole);

	initial forever #5 clk = ~clk;

	// pads are registered: compare against last cycle's sources
	always @(posedge clk)
	begin
		swPrev <= swOut;
		aoPrev <= altOut;
		aePrev <= altOe;
	end

	// {oe, out} a pin shows for its code and sources
	function logic [1:0] padExp(logic [2:0] c, logic sw, logic [5:0] ao, ae);
		int k;
		k = c[2] ? c - 4 : 7 - c;
		if (c == 3'h0)
			return 2'b00;
		if (c == 3'h1)
			return {1'b1, sw};
		return {ae[k], ao[k]};
	endfunction

	function logic [31:0] merge(logic [31:0] o, d, logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b]) o[8*b+:8] = d[8*b+:8];
		return o & 32'h3fffffff;
	endfunction

	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		input logic [3:0] st);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task give_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk);
		n_fail++;
		give_verdict;
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 12'h004, 0, 0);
		`CHK("reset", 32'h0, rd)
		for (int c = 0; c < 8; c++)
		begin
			// reserved bits written high must not stick
			apb(1, 12'h000, {2'h3, {10{3'(c)}}}, 4'hf);
			apb(1, 12'h004, {2'h3, {10{3'(c)}}}, 4'hf);
			@(posedge clk);
			`CHK("role30", roleTbl[c], pinRole[0])
			`CHK("role49", roleTbl[c], pinRole[19])
			if (c < 2) `CHK("oe", {20{c[0]}}, padOe)
			for (int p = 0; p < 20; p++)
			begin
				pe = padExp(3'(c), swPrev[p], aoPrev[6*p+:6], aePrev[6*p+:6]);
				`CHK("pad", pe, {padOe[p], padOut[p]})
			end
			apb(0, 12'h000, 0, 0);
			`CHK("rd30", {2'h0, {10{3'(c)}}}, rd)
		end
		m[0] = 32'h3fffffff;
		m[1] = 32'h3fffffff;
		repeat (40)
		begin
			idx = {$random(seed)} % 3;
			d = $random(seed);
			s = $random(seed);
			apb(1, 12'(idx * 4), d, s);
			if (idx < 2) m[idx] = merge(m[idx], d, s);
			apb(0, 12'(idx * 4), 0, 0);
			`CHK("rdback", (idx < 2) ? m[idx] : 32'h0, rd)
			`CHK("slverr", idx == 2, err)
		end
		give_verdict;
	end
endmodule // test_pin_function_select_bank
